// file: rtl/act_pkg.sv
// conversion timing and trigger control: shared constants and types
// assumes one peripheral clock domain and CPU byte/bit accesses
package act_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // trigger mode register
    localparam logic [19:0] CFG_ADDR = 20'hFFF32;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WR_MASK = 8'hE3;
    localparam int TRIG_MODE_HI = 7;
    localparam int TRIG_MODE_LO = 6;
    localparam int ONE_SHOT_BIT = 5;
    localparam int TRIG_SRC_HI = 1;
    localparam int TRIG_SRC_LO = 0;

    localparam logic [1:0] TRIG_NO_WAIT = 2'h2;
    localparam logic [1:0] TRIG_WAIT = 2'h3;
    localparam logic [1:0] SRC_TIMER = 2'h0;
    localparam logic [1:0] SRC_BAD = 2'h1;
    localparam logic [1:0] SRC_RTC = 2'h2;
    localparam logic [1:0] SRC_ITV = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // conversion clock counts
    localparam logic [4:0] SAMPLE_MODE1 = 5'h07;
    localparam logic [4:0] SAMPLE_MODE2 = 5'h05;
    localparam logic [4:0] TOTAL_MODE1 = 5'h13;
    localparam logic [4:0] TOTAL_MODE2 = 5'h11;
    localparam logic [4:0] RES8_SHORTEN = 5'h02;
    localparam logic [4:0] STAB_NORMAL = 5'h08;
    localparam logic [4:0] STAB_LOW = 5'h02;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [1:0] SCAN_FIRST_CH = 2'h0;
    localparam logic [1:0] SCAN_LAST_CH = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // divider
    localparam int DIV_W = 7;

    function automatic logic [DIV_W-1:0] div_of(input logic [2:0] sel);
        logic [DIV_W-1:0] d;
        d = 7'h40;
        unique case (sel)
            3'h0: d = 7'h40;
            3'h1: d = 7'h20;
            3'h2: d = 7'h10;
            3'h3: d = 7'h08;
            3'h4: d = 7'h06;
            3'h5: d = 7'h05;
            3'h6: d = 7'h04;
            3'h7: d = 7'h02;
        endcase
        return d;
    endfunction

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_STAB = 3'h3,
        ST_SAMPLE = 3'h2,
        ST_CONVERT = 3'h6
    } act_state_t;

endpackage

// file: rtl/act_clk_div.sv
// conversion clock divider: one-cycle tick every divisor clocks
// assumes divisor is at least 2 and held stable while counting
module act_clk_div #(
    parameter int DIV_W = 7
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [DIV_W-1:0] divisor,
    output logic tick
);

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic wrap;

    always_comb begin
        wrap = (cnt_q == divisor - {{(DIV_W-1){1'b0}}, 1'b1});
        cnt_d = cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
        if (restart || wrap) begin
            cnt_d = '0;
        end
        tick_d = wrap && !restart;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule // act_clk_div

// file: rtl/act_timing_ctrl.sv
// conversion timing and trigger control for the successive approximation converter
// assumes CPU accesses synchronous to CORE_CLK, one access per cycle
// Operation
// - conversion clock is CORE_CLK over 64,32,16,8,6,5,4,2 by divider code
// - timing mode 1 takes 19 conversion clocks, 7 of them sampling
// - timing mode 2 takes 17 conversion clocks, 5 of them sampling
// - 8-bit resolution shortens each conversion by two conversion clocks
// - wait trigger mode, normal timing: 8 stabilization clocks before sampling
// - wait trigger mode, low-voltage timing: 2 stabilization clocks before sampling
// - later sequential conversions and scan channels 1-3 skip start and stabilization
// - start time only precedes the first conversion
// - trigger mode register is 8 bits, bit or byte writable, resets 0
// - trigger mode: 0x software, 10 hardware no-wait, 11 hardware wait
// - mode in 7:6, one-shot in 5, source in 1:0, 4:2 read zero
// - one-shot 0 converts continuously, 1 converts a single pass
// - source 00 timer, 10 rtc, 11 interval timer, 01 never triggers
// - run and enable give stopped, standby, converting; run without enable returns the sequencer to idle
// - wait mode sets run on a trigger; software set of run ignored
module act_timing_ctrl (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [19:0] ADDR,
    input wire logic WE,
    input wire logic [7:0] WMASK,
    input wire logic [7:0] WDATA,
    input wire logic RE,
    output logic [7:0] RDATA,
    input wire logic [2:0] CLK_DIV_SEL,
    input wire logic [1:0] TIMING_MODE_SEL,
    input wire logic EIGHT_BIT_RES,
    input wire logic SCAN_MODE,
    input wire logic COMPARATOR_ENABLE,
    input wire logic CONV_RUN_SET,
    input wire logic CONV_RUN_CLR,
    input wire logic TIMER_CH1_EVENT,
    input wire logic RTC_EVENT,
    input wire logic INTERVAL_TIMER_EVENT,
    output logic CONV_RUN,
    output logic CONV_TICK,
    output logic STABILIZING,
    output logic SAMPLING,
    output logic CONVERTING,
    output logic CONV_DONE,
    output logic [1:0] SCAN_CHANNEL
);

    ////////////////////////////////////////////////////////////////////////////
    // register access
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic hit;
    always_comb begin
        hit = (ADDR == act_pkg::CFG_ADDR);
        cfg_d = cfg_q;
        if (WE && hit) begin
            cfg_d = ((cfg_q & ~WMASK) | (WDATA & WMASK)) & act_pkg::CFG_WR_MASK;
        end
        rdata_d = (RE && hit) ? cfg_q : 8'h00;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cfg_q <= act_pkg::CFG_RESET;
            rdata_q <= 8'h00;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode
    logic [1:0] trig_mode;
    logic [1:0] trig_src;
    logic hw_mode;
    logic wait_mode;
    logic one_shot;
    logic hw_trig;
    logic [4:0] sample_len;
    logic [4:0] conv_len;
    logic [4:0] stab_len;
    logic [4:0] total_len;
    always_comb begin
        trig_mode = cfg_q[act_pkg::TRIG_MODE_HI:act_pkg::TRIG_MODE_LO];
        trig_src = cfg_q[act_pkg::TRIG_SRC_HI:act_pkg::TRIG_SRC_LO];
        one_shot = cfg_q[act_pkg::ONE_SHOT_BIT];
        hw_mode = trig_mode[1];
        wait_mode = (trig_mode == act_pkg::TRIG_WAIT);
        unique case (trig_src)
            act_pkg::SRC_TIMER: hw_trig = TIMER_CH1_EVENT;
            act_pkg::SRC_BAD: hw_trig = 1'b0;
            act_pkg::SRC_RTC: hw_trig = RTC_EVENT;
            act_pkg::SRC_ITV: hw_trig = INTERVAL_TIMER_EVENT;
        endcase
        sample_len = TIMING_MODE_SEL[0] ? act_pkg::SAMPLE_MODE2 : act_pkg::SAMPLE_MODE1;
        total_len = TIMING_MODE_SEL[0] ? act_pkg::TOTAL_MODE2 : act_pkg::TOTAL_MODE1;
        if (EIGHT_BIT_RES) begin
            total_len = total_len - act_pkg::RES8_SHORTEN;
        end
        conv_len = total_len - sample_len;
        stab_len = TIMING_MODE_SEL[1] ? act_pkg::STAB_LOW : act_pkg::STAB_NORMAL;
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion clock
    logic tick;
    logic div_restart;
    logic [act_pkg::DIV_W-1:0] divisor;

    assign divisor = act_pkg::div_of(CLK_DIV_SEL);
    act_clk_div #(
        .DIV_W(act_pkg::DIV_W)
    ) u_div (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .restart(div_restart),
        .divisor(divisor),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer and run bit
    act_pkg::act_state_t state_q;
    act_pkg::act_state_t state_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [1:0] chan_q;
    logic [1:0] chan_d;
    logic run_q;
    logic run_d;
    logic done_q;
    logic done_d;
    logic active;
    logic run_set;
    logic auto_clr;
    logic pass_end;
    logic last_ch;

    always_comb begin
        active = run_q && COMPARATOR_ENABLE;
        state_d = state_q;
        cnt_d = cnt_q;
        chan_d = chan_q;
        done_d = 1'b0;
        auto_clr = 1'b0;
        div_restart = 1'b0;
        last_ch = !SCAN_MODE || (chan_q == act_pkg::SCAN_LAST_CH);
        pass_end = (state_q == act_pkg::ST_CONVERT) && tick && (cnt_q == act_pkg::CNT_ZERO)
            && last_ch;
        run_set = wait_mode ? (hw_trig && COMPARATOR_ENABLE && state_q == act_pkg::ST_IDLE)
            : CONV_RUN_SET;
        unique case (state_q)
            act_pkg::ST_IDLE: begin
                chan_d = act_pkg::SCAN_FIRST_CH;
                if (wait_mode) begin
                    if (hw_trig && COMPARATOR_ENABLE) begin
                        state_d = act_pkg::ST_START;
                    end
                end else if (active && (!hw_mode || hw_trig)) begin
                    state_d = act_pkg::ST_START;
                end
            end
            act_pkg::ST_START: begin
                if (wait_mode) begin
                    div_restart = 1'b1;
                    state_d = act_pkg::ST_STAB;
                    cnt_d = stab_len - act_pkg::CNT_ONE;
                end else if (tick) begin
                    state_d = act_pkg::ST_SAMPLE;
                    cnt_d = sample_len - act_pkg::CNT_ONE;
                end
            end
            act_pkg::ST_STAB: begin
                if (tick) begin
                    cnt_d = cnt_q - act_pkg::CNT_ONE;
                    if (cnt_q == act_pkg::CNT_ZERO) begin
                        state_d = act_pkg::ST_SAMPLE;
                        cnt_d = sample_len - act_pkg::CNT_ONE;
                    end
                end
            end
            act_pkg::ST_SAMPLE: begin
                if (tick) begin
                    cnt_d = cnt_q - act_pkg::CNT_ONE;
                    if (cnt_q == act_pkg::CNT_ZERO) begin
                        state_d = act_pkg::ST_CONVERT;
                        cnt_d = conv_len - act_pkg::CNT_ONE;
                    end
                end
            end
            act_pkg::ST_CONVERT: begin
                if (tick) begin
                    cnt_d = cnt_q - act_pkg::CNT_ONE;
                    if (cnt_q == act_pkg::CNT_ZERO) begin
                        done_d = 1'b1;
                        cnt_d = sample_len - act_pkg::CNT_ONE;
                        state_d = act_pkg::ST_SAMPLE;
                        if (!last_ch) begin
                            chan_d = chan_q + 2'h1;
                        end else begin
                            chan_d = act_pkg::SCAN_FIRST_CH;
                            if (one_shot) begin
                                state_d = act_pkg::ST_IDLE;
                                auto_clr = !hw_mode || wait_mode;
                            end
                        end
                    end
                end
            end
            default: begin
                state_d = act_pkg::ST_IDLE;
            end
        endcase
        if (state_q != act_pkg::ST_IDLE && state_q != act_pkg::ST_START && !active) begin
            state_d = act_pkg::ST_IDLE;
            chan_d = act_pkg::SCAN_FIRST_CH;
        end
        if (state_q == act_pkg::ST_START && !active) begin
            state_d = act_pkg::ST_IDLE;
            div_restart = 1'b0;
        end
        run_d = run_q;
        if (CONV_RUN_CLR || auto_clr) begin
            run_d = 1'b0;
        end
        if (run_set) begin
            run_d = 1'b1; // set wins over clear
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_q <= act_pkg::ST_IDLE;
            cnt_q <= act_pkg::CNT_ZERO;
            chan_q <= act_pkg::SCAN_FIRST_CH;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            chan_q <= chan_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end

    assign RDATA = rdata_q;
    assign CONV_RUN = run_q;
    assign CONV_TICK = tick;
    assign STABILIZING = (state_q == act_pkg::ST_STAB);
    assign SAMPLING = (state_q == act_pkg::ST_SAMPLE);
    assign CONVERTING = (state_q == act_pkg::ST_CONVERT);
    assign CONV_DONE = done_q;
    assign SCAN_CHANNEL = chan_q;

    ////////////////////////////////////////////////////////////////////////////
    // tick spacing helper for checks
    logic [act_pkg::DIV_W-1:0] gap_q;
    logic [act_pkg::DIV_W-1:0] gap_d;
    logic gap_ok_q;
    logic gap_ok_d;
    logic [2:0] sel_prev_q;
    always_comb begin
        gap_d = gap_q + {{(act_pkg::DIV_W-1){1'b0}}, 1'b1};
        gap_ok_d = gap_ok_q;
        if (tick) begin
            gap_d = '0;
            gap_ok_d = 1'b1;
        end
        if (div_restart || CLK_DIV_SEL != sel_prev_q) begin
            gap_ok_d = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            gap_q <= '0;
            gap_ok_q <= 1'b0;
            sel_prev_q <= 3'h0;
        end else begin
            gap_q <= gap_d;
            gap_ok_q <= gap_ok_d;
            sel_prev_q <= CLK_DIV_SEL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_DIV_PERIOD: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (tick && gap_ok_q && CLK_DIV_SEL == sel_prev_q) |-> (gap_q == divisor - 7'h01))
        else $error("conversion tick spacing does not match divider");
    AST_SAMPLE_LOAD: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q != act_pkg::ST_SAMPLE) ##1 (state_q == act_pkg::ST_SAMPLE)
        |-> (cnt_q == $past(sample_len) - act_pkg::CNT_ONE))
        else $error("sampling length wrong");
    AST_CONV_LOAD: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q == act_pkg::ST_SAMPLE) ##1 (state_q == act_pkg::ST_CONVERT)
        |-> (cnt_q == $past(conv_len) - act_pkg::CNT_ONE))
        else $error("conversion length wrong");
    AST_STAB_NORMAL: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q == act_pkg::ST_START && wait_mode && active && !TIMING_MODE_SEL[1])
        |=> (state_q == act_pkg::ST_STAB && cnt_q == act_pkg::STAB_NORMAL - act_pkg::CNT_ONE))
        else $error("normal stabilization count wrong");
    AST_STAB_LOW: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q == act_pkg::ST_START && wait_mode && active && TIMING_MODE_SEL[1])
        |=> (state_q == act_pkg::ST_STAB && cnt_q == act_pkg::STAB_LOW - act_pkg::CNT_ONE))
        else $error("low-voltage stabilization count wrong");
    AST_NO_RESTART: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (state_q == act_pkg::ST_CONVERT) |=> (state_q != act_pkg::ST_START
        && state_q != act_pkg::ST_STAB))
        else $error("start or stabilization repeated after a conversion");
    AST_RESV_ZERO: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (cfg_q & ~act_pkg::CFG_WR_MASK) == 8'h00)
        else $error("reserved bits not zero");
    AST_BIT_WRITE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (WE && hit) |=> ((cfg_q & ~$past(WMASK)) == ($past(cfg_q) & ~$past(WMASK)))
        && ((cfg_q & $past(WMASK)) == ($past(WDATA) & $past(WMASK) & act_pkg::CFG_WR_MASK)))
        else $error("masked write wrong");
    AST_SRC_BAD: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (trig_src == act_pkg::SRC_BAD && state_q == act_pkg::ST_IDLE && hw_mode)
        |=> (state_q == act_pkg::ST_IDLE))
        else $error("prohibited source started a conversion");
    AST_WAIT_SW_SET: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wait_mode && !run_q && !hw_trig) |=> !run_q)
        else $error("run set without trigger in wait mode");
    AST_ONE_SHOT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (pass_end && active && one_shot && !CONV_RUN_SET && !run_set && !CONV_RUN_CLR)
        |=> (state_q == act_pkg::ST_IDLE && run_q == $past(hw_mode && !wait_mode)))
        else $error("one-shot pass end handled wrongly");
    AST_STANDBY: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (!active && state_q != act_pkg::ST_IDLE) |=> (state_q == act_pkg::ST_IDLE))
        else $error("sequencer kept running without run and enable");

endmodule // act_timing_ctrl

// file: dv/tb_top.sv
// self-checking bench for the conversion timing and trigger controller
// assumes the controller top act_timing_ctrl and the act_pkg constants
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %0t got %0h exp %0h", $time, (got), (exp)); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic core_clk, rst_n, we, re, eight_bit_res, scan_mode, comp_en, run_set, run_clr;
    logic ev_timer, ev_rtc, ev_itv, conv_run, conv_tick, stabilizing, sampling, converting;
    logic conv_done, run_at_entry;
    logic [19:0] addr;
    logic [7:0] wmask, wdata, rdata, rd;
    logic [2:0] div_sel;
    logic [1:0] tmode_sel, scan_channel, chan_at_entry;
    int failures, check_count, cycles, done_cnt, stab_cyc;
    int divs[8] = '{64, 32, 16, 8, 6, 5, 4, 2};

    act_timing_ctrl uut (.CORE_CLK(core_clk), .RST_N(rst_n), .ADDR(addr), .WE(we),
        .WMASK(wmask), .WDATA(wdata), .RE(re), .RDATA(rdata), .CLK_DIV_SEL(div_sel),
        .TIMING_MODE_SEL(tmode_sel), .EIGHT_BIT_RES(eight_bit_res), .SCAN_MODE(scan_mode),
        .COMPARATOR_ENABLE(comp_en), .CONV_RUN_SET(run_set), .CONV_RUN_CLR(run_clr),
        .TIMER_CH1_EVENT(ev_timer), .RTC_EVENT(ev_rtc), .INTERVAL_TIMER_EVENT(ev_itv),
        .CONV_RUN(conv_run), .CONV_TICK(conv_tick), .STABILIZING(stabilizing),
        .SAMPLING(sampling), .CONVERTING(converting), .CONV_DONE(conv_done),
        .SCAN_CHANNEL(scan_channel));

    ////////////////////////////////////////////////////////////////////////////
    // clock, monitors, hang guard
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (conv_done === 1'b1) done_cnt++;
        if (stabilizing === 1'b1) stab_cyc++;
        if (cycles == 30000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // drivers
    task automatic reg_wr(input logic [19:0] a, input logic [7:0] m, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a; wmask <= m; wdata <= d; we <= 1'b1;
        @(posedge core_clk);
        we <= 1'b0;
    endtask

    task automatic reg_rd(input logic [19:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a; re <= 1'b1;
        @(posedge core_clk);
        re <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask

    // 0 run set, 1 run clear, 2 timer, 3 rtc, 4 interval timer
    task automatic pulse(input int sel);
        @(posedge core_clk);
        {run_set, run_clr, ev_timer, ev_rtc, ev_itv} <= 5'h10 >> sel;
        @(posedge core_clk);
        {run_set, run_clr, ev_timer, ev_rtc, ev_itv} <= 5'h00;
    endtask

    // settings only change with enable dropped and run already clear
    task automatic cfg(input logic [2:0] dv, input logic [1:0] tm, input logic r8,
                       input logic sc, input logic [7:0] rv);
        @(posedge core_clk);
        comp_en <= 1'b0;
        @(posedge core_clk);
        div_sel <= dv; tmode_sel <= tm; eight_bit_res <= r8; scan_mode <= sc;
        reg_wr(act_pkg::CFG_ADDR, 8'hFF, rv);
        @(posedge core_clk);
        comp_en <= 1'b1;
    endtask

    function automatic logic phase(input int sel);
        return (sel == 0) ? stabilizing : (sel == 1) ? sampling : converting;
    endfunction

    task automatic count_phase(input int sel, output int cyc, output int tk);
        int n;
        n = 0;
        cyc = 0;
        tk = 0;
        while (phase(sel) !== 1'b1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        run_at_entry = conv_run;
        chan_at_entry = scan_channel;
        while (phase(sel) === 1'b1) begin
            cyc++;
            if (conv_tick === 1'b1) tk++;
            @(negedge core_clk);
        end
    endtask

    task automatic conv_check(input int dv, input int st, input int sp, input int cv);
        int c, t, d0;
        d0 = done_cnt;
        if (st > 0) begin
            count_phase(0, c, t);
            `CHK(t, st);
            `CHK(run_at_entry, 1'b1);
        end
        count_phase(1, c, t);
        `CHK(t, sp);
        `CHK(c, sp * dv);
        count_phase(2, c, t);
        `CHK(t, cv);
        `CHK(c, cv * dv);
        repeat (2) @(negedge core_clk);
        `CHK(done_cnt, d0 + 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_regs();
        reg_rd(act_pkg::CFG_ADDR, rd);
        `CHK(rd, 8'h00);
        reg_wr(act_pkg::CFG_ADDR, 8'hFF, 8'hFF);
        reg_rd(act_pkg::CFG_ADDR, rd);
        `CHK(rd, 8'hE3);
        reg_wr(act_pkg::CFG_ADDR, 8'h80, 8'h00);
        reg_rd(act_pkg::CFG_ADDR, rd);
        `CHK(rd, 8'h63);
        reg_wr(act_pkg::CFG_ADDR, 8'h1C, 8'h1C);
        reg_wr(20'hFFF33, 8'hFF, 8'h00);
        reg_rd(act_pkg::CFG_ADDR, rd);
        `CHK(rd, 8'h63);
        reg_rd(20'hFFF33, rd);
        `CHK(rd, 8'h00);
        $display("test regs ended");
    endtask

    task automatic test_divider();
        int s0;
        for (int k = 0; k < 8; k++) begin
            cfg(k[2:0], 2'h0, 1'b0, 1'b0, 8'h20); // 10 MHz core clock, no prohibited point
            s0 = stab_cyc;
            pulse(0);
            conv_check(divs[k], 0, 7, 12);
            `CHK(conv_run, 1'b0);
            `CHK(stab_cyc, s0);
        end
        $display("test divider ended");
    endtask

    task automatic test_modes();
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 2; r++) begin
                cfg(3'h7, m[1:0], r[0], 1'b0, 8'h60);
                pulse(0);
                conv_check(2, 0, m[0] ? 5 : 7, 12 - 2 * r);
            end
        end
        $display("test modes ended");
    endtask

    task automatic test_wait();
        int srcs[3] = '{0, 2, 3};
        int tms[3] = '{0, 2, 3};
        int stabs[3] = '{8, 2, 2};
        for (int i = 0; i < 3; i++) begin
            cfg(3'h6, tms[i][1:0], 1'b0, 1'b0, 8'hE0 | srcs[i][7:0]);
            pulse(srcs[i] == 0 ? 2 : srcs[i] + 1); // one trigger per full wait+conversion
            conv_check(4, stabs[i], tms[i][0] ? 5 : 7, 12);
            `CHK(conv_run, 1'b0);
        end
        $display("test wait ended");
    endtask

    task automatic test_refused();
        int d0;
        d0 = done_cnt;
        cfg(3'h7, 2'h0, 1'b0, 1'b0, 8'hE1);
        for (int s = 2; s < 5; s++) pulse(s);
        repeat (100) @(negedge core_clk);
        `CHK(conv_run, 1'b0);
        `CHK(done_cnt, d0);
        cfg(3'h7, 2'h0, 1'b0, 1'b0, 8'hE0);
        pulse(0);
        repeat (50) @(negedge core_clk);
        `CHK(conv_run, 1'b0);
        cfg(3'h7, 2'h0, 1'b0, 1'b0, 8'hA0);
        pulse(0);
        repeat (60) @(negedge core_clk);
        `CHK(done_cnt, d0);
        `CHK(conv_run, 1'b1);
        pulse(2);
        conv_check(2, 0, 7, 12);
        `CHK(conv_run, 1'b1);
        pulse(1);
        repeat (3) @(negedge core_clk);
        `CHK(conv_run, 1'b0);
        $display("test refused ended");
    endtask

    task automatic test_scan_seq();
        int c, t, s0;
        cfg(3'h7, 2'h0, 1'b0, 1'b1, 8'hC0);
        pulse(2);
        count_phase(0, c, t);
        `CHK(t, 8);
        s0 = stab_cyc;
        for (int k = 0; k < 5; k++) begin
            count_phase(1, c, t);
            `CHK(chan_at_entry, k % 4);
            `CHK(c, 14);
        end
        `CHK(stab_cyc, s0);
        pulse(1);
        repeat (10) @(negedge core_clk);
        `CHK({conv_run, stabilizing, sampling, converting}, 4'h0);
        $display("test scan_seq ended");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_n = 1'b0; we = 1'b0; re = 1'b0; addr = '0; wmask = '0; wdata = '0;
        div_sel = '0; tmode_sel = '0; eight_bit_res = 1'b0; scan_mode = 1'b0;
        comp_en = 1'b0; run_set = 1'b0; run_clr = 1'b0;
        ev_timer = 1'b0; ev_rtc = 1'b0; ev_itv = 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        `CHK({conv_run, conv_tick, stabilizing, sampling, converting, conv_done}, 6'h00);
        test_regs();
        test_divider();
        test_modes();
        test_wait();
        test_refused();
        test_scan_seq();
        give_verdict();
    end
endmodule // tb_top
